// ===== hdl/fpr_pkg.sv
package fpr_pkg;
  // Physical array geometry
  localparam int ARRAY_AW = 9;  // Array address width
  localparam int ARRAY_DW = 16;  // Array word width
  localparam int ARRAY_DEPTH = 512;  // Words in the array
  // Configured user-side widths (3..9 and 3..16 allowed)
  localparam int USER_AW = 9;
  localparam int USER_DW = 16;
  localparam int ADDR_PAD = ARRAY_AW - USER_AW;
  localparam int DATA_PAD = ARRAY_DW - USER_DW;
  localparam int SECTOR_BIT = ARRAY_AW - 1;  // Sector select bit
  localparam int SECTOR_WORDS = ARRAY_DEPTH / 2;
  // Clock figures
  localparam int CLK_PERIOD_NS = 100;
  // Request pulse width window
  localparam int T_CMD_MIN_NS = 600;
  localparam int T_CMD_MAX_NS = 3000;
  localparam int T_HOLD_MIN_NS = 600;  // Address/data hold after fall
  localparam int T_BUSY_MAX_NS = 300;  // Fall to busy low, longest
  // Cycle counts derived from the times
  localparam int CMD_MIN_CYC =
    (T_CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_MAX_CYC = T_CMD_MAX_NS / CLK_PERIOD_NS;
  localparam int HOLD_MIN_CYC =
    (T_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_MAX_CYC = T_BUSY_MAX_NS / CLK_PERIOD_NS;
  // Internal operation lengths in cycles (plain defaults)
  localparam int READ_CYC = 4;
  localparam int PROG_CYC = 16;
  localparam int ERASE_CYC = 64;
  localparam int CNT_W = 8;
  // Erased word value
  localparam logic [ARRAY_DW-1:0] ERASED_WORD = 16'hffff;
  // Requester pulse width used, inside the legal window
  localparam int REQ_PULSE_CYC = CMD_MIN_CYC + 1;
  // Request kinds
  typedef enum logic [1:0] {
    FPR_OP_READ,
    FPR_OP_WRITE,
    FPR_OP_ERASE
  } fpr_op_t;
endpackage

// ===== hdl/fpr_if.sv
interface fpr_if;
  import fpr_pkg::*;
  logic read_request_n;  // Active-low read request
  logic write_request_n;  // Active-low write request
  logic erase_request_n;  // Active-low sector erase request
  logic [USER_AW-1:0] addr;  // Request address
  logic [USER_DW-1:0] write_data_in;  // Data to program
  logic [USER_DW-1:0] data_out;  // Read result
  logic operation_pending_n;  // Low while busy
  logic data_valid;  // High after a finished read
  logic oscillator_enable;  // Always high
  modport flash (
    input read_request_n, write_request_n, erase_request_n, addr,
    input write_data_in,
    output data_out, operation_pending_n, data_valid, oscillator_enable
  );
  modport requester (
    output read_request_n, write_request_n, erase_request_n, addr,
    output write_data_in,
    input data_out, operation_pending_n, data_valid, oscillator_enable
  );
endinterface

// ===== hdl/fpr_flash.sv
module fpr_flash #(
  parameter bit READ_ONLY = 1'b0  // Read-only configuration
) (
  input wire logic CLK,
  input wire logic SRST,
  fpr_if.flash LINK
);
  import fpr_pkg::*;

  typedef enum logic [1:0] {
    FPR_IDLE,
    FPR_HOLD,
    FPR_WORK
  } fpr_state_t;

  // Synchroniser stages for the three request pins
  logic [2:0] req_s1_r;  // First stage, read only by second
  logic [2:0] req_s2_r;  // Second stage
  logic [2:0] req_s3_r;  // Previous value for edge detection
  logic [2:0] fall;  // Falling edge per request line
  fpr_state_t state_r;
  logic [CNT_W-1:0] cnt_r;  // Operation timer
  fpr_op_t op_r;  // Operation in progress
  logic [ARRAY_AW-1:0] addr_r;  // Full array address
  logic [ARRAY_DW-1:0] wdata_r;  // Full array word
  logic [ARRAY_DW-1:0] mem [ARRAY_DEPTH];  // The array itself
  logic [ARRAY_DW-1:0] rword_r;  // Fetched word
  logic busy_n_r;
  logic valid_r;
  logic [USER_DW-1:0] dout_r;
  logic one_req;  // Exactly one line fell, none other low
  logic accept;
  logic osc_en_r;  // Oscillator enable, set and never cleared

  // Two flops before any logic looks at the pins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      req_s1_r <= 3'h7;
      req_s2_r <= 3'h7;
      req_s3_r <= 3'h7;
    end else begin
      req_s1_r <= {LINK.erase_request_n, LINK.write_request_n,
                   LINK.read_request_n};
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  assign fall = req_s3_r & ~req_s2_r;
  // Exactly one line low; a second low line voids it
  assign one_req = (fall != 3'h0) &&
                   ((~req_s2_r == 3'h1) || (~req_s2_r == 3'h2) ||
                    (~req_s2_r == 3'h4));
  // Edges while busy are dropped; only idle accepts
  assign accept = (state_r == FPR_IDLE) && one_req &&
                  (!READ_ONLY || fall[0]);

  // Sequencer: hold window, then internal operation
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= FPR_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        FPR_IDLE: begin
          if (accept) begin
            state_r <= FPR_HOLD;
            cnt_r <= '0;
          end
        end
        // Sit out the hold time before the array is touched
        FPR_HOLD: begin
          if (cnt_r == CNT_W'(HOLD_MIN_CYC - 3)) begin
            state_r <= FPR_WORK;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        FPR_WORK: begin
          if ((op_r == FPR_OP_READ && cnt_r == CNT_W'(READ_CYC - 1)) ||
              (op_r == FPR_OP_WRITE && cnt_r == CNT_W'(PROG_CYC - 1)) ||
              (op_r == FPR_OP_ERASE && cnt_r == CNT_W'(ERASE_CYC - 1)))
          begin
            state_r <= FPR_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= FPR_IDLE;
      endcase
    end
  end

  // Request kind latched on acceptance
  always_ff @(posedge CLK) begin
    if (SRST) begin
      op_r <= FPR_OP_READ;
    end else if (accept) begin
      if (fall[0]) begin
        op_r <= FPR_OP_READ;
      end else if (fall[1]) begin
        op_r <= FPR_OP_WRITE;
      end else begin
        op_r <= FPR_OP_ERASE;
      end
    end
  end

  // Address and data padded out to array width early in the hold.
  // Captured at the first hold cycle: a requester need only keep the
  // buses for the hold time after its fall, and a fall just after an
  // edge would leave a capture at the end of the hold too late.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      addr_r <= '0;
      wdata_r <= ERASED_WORD;
    end else if (state_r == FPR_HOLD && cnt_r == '0) begin
      if (ADDR_PAD > 0) begin
        // Low bits zero
        addr_r <= ARRAY_AW'({LINK.addr, {ARRAY_AW{1'b0}}} >> USER_AW);
      end else begin
        addr_r <= ARRAY_AW'(LINK.addr);
      end
      if (DATA_PAD > 0) begin
        // Low bits one
        wdata_r <= ARRAY_DW'({LINK.write_data_in, {ARRAY_DW{1'b1}}} >>
                             USER_DW);
      end else begin
        wdata_r <= ARRAY_DW'(LINK.write_data_in);
      end
    end
  end

  // Array: read, program, sector erase; not reset (nonvolatile)
  always_ff @(posedge CLK) begin
    if (state_r == FPR_WORK && cnt_r == '0) begin
      case (op_r)
        FPR_OP_READ: rword_r <= mem[addr_r];
        FPR_OP_WRITE: mem[addr_r] <= wdata_r;
        default: begin
          // MSB picks the sector
          for (int i = 0; i < SECTOR_WORDS; i++) begin
            mem[{addr_r[SECTOR_BIT], (ARRAY_AW-1)'(i)}] <= ERASED_WORD;
          end
        end
      endcase
    end
  end

  // Busy low from acceptance until the operation ends
  always_ff @(posedge CLK) begin
    if (SRST) begin
      busy_n_r <= 1'b1;
    end else if (accept) begin
      busy_n_r <= 1'b0;
    end else if (state_r == FPR_WORK && state_r != FPR_IDLE &&
                 ((op_r == FPR_OP_READ && cnt_r == CNT_W'(READ_CYC - 1)) ||
                  (op_r == FPR_OP_WRITE && cnt_r == CNT_W'(PROG_CYC - 1)) ||
                  (op_r == FPR_OP_ERASE &&
                   cnt_r == CNT_W'(ERASE_CYC - 1)))) begin
      busy_n_r <= 1'b1;
    end
  end

  // Data valid and output word
  always_ff @(posedge CLK) begin
    if (SRST) begin
      valid_r <= 1'b0;
      dout_r <= '0;
    end else if (accept) begin
      valid_r <= 1'b0;
    end else if (state_r == FPR_WORK && op_r == FPR_OP_READ &&
                 cnt_r == CNT_W'(READ_CYC - 1)) begin
      valid_r <= 1'b1;
      // User word is the top bits, MSB first
      dout_r <= rword_r[ARRAY_DW-1 -: USER_DW];
    end
  end

  // Oscillator enable from a flop so the pin is a register output;
  // no reset or mode clears it, read-only included
  always_ff @(posedge CLK) begin
    osc_en_r <= 1'b1;
  end

  assign LINK.operation_pending_n = busy_n_r;
  assign LINK.data_valid = valid_r;
  assign LINK.data_out = dout_r;
  assign LINK.oscillator_enable = osc_en_r;
endmodule

// ===== hdl/fpr_requester.sv
// Requester end: issues one request at a time with legal timing
module fpr_requester (
  input wire logic CLK,
  input wire logic SRST,
  fpr_if.requester LINK,
  input wire logic REQ_VALID,
  input wire fpr_pkg::fpr_op_t REQ_OP,
  input wire logic [fpr_pkg::USER_AW-1:0] REQ_ADDR,
  input wire logic [fpr_pkg::USER_DW-1:0] REQ_DATA,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [fpr_pkg::USER_DW-1:0] RD_DATA
);
  import fpr_pkg::*;

  typedef enum logic [1:0] {
    FPQ_IDLE,
    FPQ_PULSE,
    FPQ_WAIT
  } fpq_state_t;

  fpq_state_t state_r;
  logic [CNT_W-1:0] cnt_r;  // Pulse and settle timer
  logic [2:0] req_n_r;  // Erase, write, read lines
  logic [USER_AW-1:0] addr_r;
  logic [USER_DW-1:0] data_r;
  logic busy_s1_r, busy_s2_r;  // Busy synchroniser
  logic val_s1_r, val_s2_r, val_s3_r;  // Valid synchroniser, edge stage
  logic rd_valid_r;
  logic [USER_DW-1:0] rd_data_r;
  logic ready_r;

  // Busy and valid outputs pass two flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
      val_s1_r <= 1'b0;
      val_s2_r <= 1'b0;
      val_s3_r <= 1'b0;
    end else begin
      busy_s1_r <= LINK.operation_pending_n;
      busy_s2_r <= busy_s1_r;
      val_s1_r <= LINK.data_valid;
      val_s2_r <= val_s1_r;
      val_s3_r <= val_s2_r;  // Edge stage, fed by the second stage only
    end
  end

  // One line low at a time held the window
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= FPQ_IDLE;
      cnt_r <= '0;
      req_n_r <= 3'h7;
      addr_r <= '0;
      data_r <= '0;
      ready_r <= 1'b0;
    end else begin
      case (state_r)
        FPQ_IDLE: begin
          ready_r <= busy_s2_r;
          if (REQ_VALID && ready_r && busy_s2_r) begin
            ready_r <= 1'b0;
            addr_r <= REQ_ADDR;  // Held through pulse
            data_r <= REQ_DATA;
            cnt_r <= '0;
            req_n_r <= (REQ_OP == FPR_OP_READ) ? 3'h6 :
                       (REQ_OP == FPR_OP_WRITE) ? 3'h5 : 3'h3;
            state_r <= FPQ_PULSE;
          end
        end
        FPQ_PULSE: begin
          if (cnt_r == CNT_W'(REQ_PULSE_CYC - 1)) begin
            req_n_r <= 3'h7;
            cnt_r <= '0;
            state_r <= FPQ_WAIT;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        FPQ_WAIT: begin
          // Wait until busy seen high again after settle
          if (busy_s2_r && cnt_r == CNT_W'(BUSY_MAX_CYC)) begin
            state_r <= FPQ_IDLE;
          end else if (cnt_r != CNT_W'(BUSY_MAX_CYC)) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= FPQ_IDLE;
      endcase
    end
  end

  // Catch a finished read as a one-cycle pulse
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      // Rise taken past the synchroniser; the first stage may be unsettled
      rd_valid_r <= val_s2_r && !val_s3_r;
      if (val_s2_r && !val_s3_r) begin
        rd_data_r <= LINK.data_out;
      end
    end
  end

  assign LINK.read_request_n = req_n_r[0];
  assign LINK.write_request_n = req_n_r[1];
  assign LINK.erase_request_n = req_n_r[2];
  assign LINK.addr = addr_r;
  assign LINK.write_data_in = data_r;
  assign REQ_READY = ready_r;
  assign RD_VALID = rd_valid_r;
  assign RD_DATA = rd_data_r;
endmodule

// ===== verification/fpr_monitor.sv
// Watches the link between requester and flash ends
module fpr_monitor (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic read_request_n,
  input wire logic write_request_n,
  input wire logic erase_request_n,
  input wire logic operation_pending_n,
  input wire logic data_valid,
  input wire logic oscillator_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // Busy falls: an operation was accepted
  sequence s_start;
    $fell(operation_pending_n);
  endsequence
  // One line falls while the flash is idle
  sequence s_fall;
    operation_pending_n && ($fell(read_request_n) ||
      $fell(write_request_n) || $fell(erase_request_n));
  endsequence
  property p_osc;
    oscillator_enable;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator enable low");
  // Synchroniser delay still fits the busy window
  property p_fast;
    s_fall |-> ##[1:3] !operation_pending_n;
  endproperty
  a_fast: assert property (p_fast)
    else $error("busy late after request");
  // Shortest operation is a read: hold plus read length
  property p_hold;
    s_start |-> !operation_pending_n [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("busy ended early");
  // Longest operation is an erase: hold plus erase length
  property p_end;
    s_start |-> ##[8:68] operation_pending_n;
  endproperty
  a_end: assert property (p_end)
    else $error("busy never returned");
  property p_dv_drop;
    s_start |-> !data_valid;
  endproperty
  a_dv_drop: assert property (p_dv_drop)
    else $error("data valid kept on new request");
  property p_dv_rise;
    $rose(data_valid) |-> $rose(operation_pending_n);
  endproperty
  a_dv_rise: assert property (p_dv_rise)
    else $error("data valid off busy end");
  property p_dv_keep;
    $fell(data_valid) |-> $fell(operation_pending_n);
  endproperty
  a_dv_keep: assert property (p_dv_keep)
    else $error("data valid dropped alone");
  // No line low: nothing may start
  property p_idle;
    operation_pending_n && read_request_n && write_request_n &&
      erase_request_n |=> operation_pending_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("busy without request");
  property p_pulse;
    $fell(read_request_n) |-> !read_request_n [*6] ##[0:24] read_request_n;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("request pulse width");
endmodule

// ===== verification/flash_parallel_request_port_tb.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module flash_parallel_request_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fpr_pkg::*;
  localparam int HOLD_C = 4;  // Busy cycles before the array work
  logic clk, srst, req_valid, req_ready, rd_valid;
  fpr_op_t req_op;
  logic [USER_AW-1:0] req_addr;
  logic [USER_DW-1:0] req_data, rd_data;
  int bad_count, checked;
  fpr_if if_a ();  // Both design ends
  fpr_if if_b ();  // Bench drives a read-only flash
  fpr_flash i_fpr_flash (.CLK(clk), .SRST(srst), .LINK(if_a));
  fpr_requester i_fpr_requester (.CLK(clk), .SRST(srst), .LINK(if_a),
    .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ADDR(req_addr),
    .REQ_DATA(req_data), .REQ_READY(req_ready), .RD_VALID(rd_valid),
    .RD_DATA(rd_data));
  fpr_flash #(.READ_ONLY(1'b1)) i_fpr_flash_b (.CLK(clk), .SRST(srst),
    .LINK(if_b));
  fpr_monitor i_fpr_monitor (.CLK(clk), .SRST(srst),
    .read_request_n(if_a.read_request_n),
    .write_request_n(if_a.write_request_n),
    .erase_request_n(if_a.erase_request_n),
    .operation_pending_n(if_a.operation_pending_n),
    .data_valid(if_a.data_valid),
    .oscillator_enable(if_a.oscillator_enable));
  // Verdict, reached from the tests or the watchdog
  task automatic test_done();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One request through the requester; counts busy cycles
  task automatic do_req(input fpr_op_t op, input logic [8:0] a,
    input logic [15:0] d, input logic [15:0] exp);
    int n, lo, len;
    len = (op == FPR_OP_READ) ? READ_CYC :
      (op == FPR_OP_WRITE) ? PROG_CYC : ERASE_CYC;
    lo = 0;
    n = 0;
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    `CHK(req_ready, 1'b1)
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    // Reads finish on the result pulse, others on ready
    do begin
      @(negedge clk);
      lo += (if_a.operation_pending_n === 1'b0);
      n++;
    end while (n < 200 &&
      (op == FPR_OP_READ ? rd_valid : req_ready) !== 1'b1);
    `CHK(n < 200, 1'b1)
    `CHK(lo, HOLD_C + len)
    if (op == FPR_OP_READ) begin
      `CHK(rd_data, exp)
      `CHK(if_a.data_valid, 1'b1)
      `CHK(if_a.data_out, exp)
    end
  endtask
  // Pulses the chosen lines np times on the second link, each for the
  // shortest legal width and one cycle apart, so a repeat falls in busy
  task automatic bpulse(input logic [2:0] ln, input int np, input int exp);
    int lo;
    logic on;
    lo = 0;
    for (int i = 0; i < 96; i++) begin
      @(negedge clk);
      on = (i % (CMD_MIN_CYC + 1) < CMD_MIN_CYC) &&
        (i / (CMD_MIN_CYC + 1) < np);
      if_b.read_request_n = !(on && ln[0]);
      if_b.write_request_n = !(on && ln[1]);
      if_b.erase_request_n = !(on && ln[2]);
      lo += (if_b.operation_pending_n === 1'b0);
    end
    `CHK(lo, exp)
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, well past the expected run
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    req_op = FPR_OP_READ;
    req_addr = 9'h000;
    req_data = 16'h0000;
    if_b.read_request_n = 1'b1;
    if_b.write_request_n = 1'b1;
    if_b.erase_request_n = 1'b1;
    if_b.addr = 9'h005;
    if_b.write_data_in = 16'h5a5a;
    bad_count = 0;
    checked = 0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    `CHK(if_a.oscillator_enable, 1'b1)
    `CHK(if_b.oscillator_enable, 1'b1)
    `CHK(if_a.operation_pending_n, 1'b1)
    repeat (3) @(negedge clk);
    do_req(FPR_OP_WRITE, 9'h001, 16'h1234, 16'h0000);
    do_req(FPR_OP_WRITE, 9'h100, 16'habcd, 16'h0000);
    do_req(FPR_OP_READ, 9'h001, 16'h0000, 16'h1234);
    do_req(FPR_OP_READ, 9'h100, 16'h0000, 16'habcd);
    do_req(FPR_OP_ERASE, 9'h0ff, 16'h0000, 16'h0000);
    do_req(FPR_OP_READ, 9'h001, 16'h0000, 16'hffff);
    do_req(FPR_OP_READ, 9'h100, 16'h0000, 16'habcd);
    do_req(FPR_OP_ERASE, 9'h1ff, 16'h0000, 16'h0000);
    do_req(FPR_OP_READ, 9'h100, 16'h0000, 16'hffff);
    do_req(FPR_OP_WRITE, 9'h1ff, 16'h00f0, 16'h0000);
    do_req(FPR_OP_READ, 9'h1ff, 16'h0000, 16'h00f0);
    bpulse(3'b010, 1, 0);
    bpulse(3'b100, 1, 0);
    bpulse(3'b011, 1, 0);
    bpulse(3'b101, 1, 0);
    bpulse(3'b001, 2, HOLD_C + READ_CYC);
    `CHK(if_b.data_valid, 1'b1)
    test_done();
  end
endmodule
